// *** sscs_pkg.sv ***
package sscs_pkg;

  // ----------------------------------------------------------------
  // register map (word aligned byte addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] ADR_PIN_MODE  = 5'h00;
  localparam logic [4:0] ADR_HS_OSC    = 5'h04;
  localparam logic [4:0] ADR_MAIN_MODE = 5'h08;
  localparam logic [4:0] ADR_INT_OSC   = 5'h0C;
  localparam logic [4:0] ADR_CPU_DIV   = 5'h10;
  localparam logic [4:0] ADR_STAB_SEL  = 5'h14;
  localparam logic [4:0] ADR_STAB_CNT  = 5'h18;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_EXT_CLK_SELECT    = 7;
  localparam int BIT_OSC_PIN_SELECT    = 6;
  localparam int BIT_HS_CLK_STOP       = 7;
  localparam int BIT_PERIPH_SRC_SELECT = 2;
  localparam int BIT_MAIN_SRC_STATUS   = 1;
  localparam int BIT_MAIN_SRC_SELECT   = 0;
  localparam int BIT_INT_OSC_STABLE    = 7;
  localparam int BIT_INT_OSC_STOP      = 0;

  // ----------------------------------------------------------------
  // reset values and divider codes
  // ----------------------------------------------------------------
  localparam logic       RST_HS_CLK_STOP = 1'b1;
  localparam logic [2:0] RST_CPU_DIV     = 3'h1;
  localparam logic [2:0] RST_STAB_SEL    = 3'h7;
  localparam logic [2:0] DIV_CODE_MAX    = 3'h4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_PS    = 5000;
  localparam int          INT_STAB_NS      = 1000;
  localparam int          INT_STAB_CYC     = (INT_STAB_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [8:0]  INT_STAB_CNT_MAX = INT_STAB_CYC[8:0];
  localparam logic [7:0]  INT_OSC_DIV_LAST = 8'h18;
  localparam logic [15:0] STAB_BASE        = 16'h0100;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        ext_clk_select;
    logic        osc_pin_select;
    logic        hs_clk_stop;
    logic        periph_src_select;
    logic        periph_src_locked;
    logic        main_src_select;
    logic        main_src_status;
    logic        int_osc_stop;
    logic        int_osc_stable;
    logic        stop_mode;
    logic        wake_wait;
    logic [2:0]  cpu_div;
    logic [2:0]  stab_sel;
    logic [15:0] stab_cnt;
    logic [7:0]  int_div_cnt;
    logic [8:0]  int_stab_cnt;
    logic        int_pulse;
    logic        hs_pulse;
    logic [2:0]  xtal_sync;
    logic [2:0]  ext_sync;
    logic        xtal_lvl;
    logic        ext_lvl;
    logic        ack;
    logic [31:0] rdata;
  } sscs_state_s;

  typedef struct packed {
    logic [3:0] cnt;
    logic [2:0] code;
    logic       cpu_en;
  } sscs_div_state_s;

endpackage

// *** sscs_div_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface sscs_div_if;
  logic       main_en;
  logic       run;
  logic [2:0] code;
  logic       cpu_en;

  modport src (output main_en, output run, output code, input cpu_en);
  modport div (input main_en, input run, input code, output cpu_en);
endinterface
`default_nettype wire

// *** sscs_cpu_div.sv ***
`timescale 1ns/1ps
`default_nettype none
module sscs_cpu_div
  import sscs_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n_sync,
  // divider link
  sscs_div_if.div   dv
);

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  function automatic logic [3:0] div_last(input logic [2:0] code);
    div_last = 4'((5'h01 << code) - 5'h01);
  endfunction

  sscs_div_state_s st_ff;
  sscs_div_state_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.cpu_en = 1'b0;
    if (dv.main_en && dv.run) begin
      // code only changes at a period boundary, so no short cpu period
      if (st_ff.cnt == div_last(st_ff.code)) begin
        nxt_st.cnt    = 4'h0;
        nxt_st.cpu_en = 1'b1;
        nxt_st.code   = dv.code;
      end else begin
        nxt_st.cnt = 4'(st_ff.cnt + 4'h1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      st_ff <= '{cnt: 4'h0, code: RST_CPU_DIV, cpu_en: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dv.cpu_en = st_ff.cpu_en;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_CPU_EN_FROM_MAIN: assert property (@(posedge clk) disable iff (!rst_n_sync)
    st_ff.cpu_en |-> $past(dv.main_en) && $past(dv.run))
    else $error("cpu enable without main enable");

  AST_CPU_PERIOD: assert property (@(posedge clk) disable iff (!rst_n_sync)
    st_ff.cpu_en |-> $past(st_ff.cnt) == div_last($past(st_ff.code)))
    else $error("cpu period cut short");

endmodule
`default_nettype wire

// *** sscs_top.sv ***
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - pin select 1, ext select 0: pins run the crystal oscillator.
// - both selects 1: pin a stays port, pin b takes external clock.
// - after reset both high-speed pins are input ports.
// - clearing hs stop starts crystal or enables external clock input.
// - setting hs stop halts crystal or disables external clock input.
// - periph select and main select 1: high-speed clock feeds main and periph.
// - periph select 0: internal for both; 1 with main 0: periph high-speed.
// - main on high-speed forces periph onto high-speed too.
// - cpu clock is main divided by 1,2,4,8,16; other codes refused.
// - stop request enters stop mode and halts high-speed clock.
// - read-only status shows 1 on high-speed, 0 on internal clock.
// - clearing internal stop restarts internal oscillator.
// - internal stable flag rises once oscillator settled.
// - after reset internal oscillator runs and drives cpu.
// - ext select bit 7, pin select bit 6 of pin mode register.
// - periph select bit 2, main select bit 0 of main mode register.
// - periph select may change once per reset; later writes ignored.
module sscs_top
  import sscs_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // oscillator pins
  input  wire logic        xtal_osc_in,
  input  wire logic        ext_clk_pin_in,
  output logic             xtal_amp_en,
  output logic             ext_clk_in_en,
  output logic             port_pin_a_is_port,
  output logic             port_pin_b_is_port,
  // standby
  input  wire logic        stop_req,
  input  wire logic        wake_req,
  output logic             stop_mode,
  // clock enables
  output logic             main_clk_en,
  output logic             periph_clk_en,
  output logic             cpu_clk_en
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  logic       rst_n_sync;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n_sync = rst_sync_ff[1];

  // ----------------------------------------------------------------
  // state and derived levels
  // ----------------------------------------------------------------
  sscs_state_s st_ff;
  sscs_state_s nxt_st;
  sscs_div_if  div_if ();

  logic hs_run;
  logic int_run;
  logic xtal_mode;
  logic ext_mode;
  logic want_hs;
  logic stab_done;
  logic req;
  logic wr_go;

  assign xtal_mode = st_ff.osc_pin_select && !st_ff.ext_clk_select;
  assign ext_mode  = st_ff.osc_pin_select && st_ff.ext_clk_select;
  assign hs_run    = st_ff.osc_pin_select && !st_ff.hs_clk_stop && !st_ff.stop_mode;
  assign int_run   = !st_ff.int_osc_stop && !st_ff.stop_mode;
  assign want_hs   = st_ff.periph_src_select && st_ff.main_src_select;
  // only after a wake does cpu on high-speed wait for the settle count
  assign stab_done = !st_ff.main_src_status || !st_ff.wake_wait ||
                     (st_ff.stab_cnt >= (STAB_BASE << st_ff.stab_sel));
  assign req       = read || write;
  assign wr_go     = write && st_ff.ack && byteenable[0];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.int_pulse = 1'b0;
    nxt_st.hs_pulse  = 1'b0;

    // pin inputs: three stages, a change counts once stages two and three agree
    nxt_st.xtal_sync = {st_ff.xtal_sync[1:0], xtal_osc_in};
    nxt_st.ext_sync  = {st_ff.ext_sync[1:0], ext_clk_pin_in};
    if (st_ff.xtal_sync[1] == st_ff.xtal_sync[2]) begin
      nxt_st.xtal_lvl = st_ff.xtal_sync[2];
    end
    if (st_ff.ext_sync[1] == st_ff.ext_sync[2]) begin
      nxt_st.ext_lvl = st_ff.ext_sync[2];
    end
    if (hs_run) begin
      if (xtal_mode && nxt_st.xtal_lvl && !st_ff.xtal_lvl) begin
        nxt_st.hs_pulse = 1'b1;
      end
      if (ext_mode && nxt_st.ext_lvl && !st_ff.ext_lvl) begin
        nxt_st.hs_pulse = 1'b1;
      end
    end

    // stabilisation counter runs only while the high-speed source runs
    if (!hs_run) begin
      nxt_st.stab_cnt = 16'h0000;
    end else if (st_ff.hs_pulse && st_ff.stab_cnt != 16'hFFFF) begin
      nxt_st.stab_cnt = 16'(st_ff.stab_cnt + 16'h0001);
    end

    // internal oscillator model and its settle timer
    if (!int_run) begin
      nxt_st.int_div_cnt    = 8'h00;
      nxt_st.int_stab_cnt   = 9'h000;
      nxt_st.int_osc_stable = 1'b0;
    end else begin
      if (st_ff.int_div_cnt == INT_OSC_DIV_LAST) begin
        nxt_st.int_div_cnt = 8'h00;
        nxt_st.int_pulse   = 1'b1;
      end else begin
        nxt_st.int_div_cnt = 8'(st_ff.int_div_cnt + 8'h01);
      end
      if (st_ff.int_stab_cnt == INT_STAB_CNT_MAX) begin
        nxt_st.int_osc_stable = 1'b1;
      end else begin
        nxt_st.int_stab_cnt = 9'(st_ff.int_stab_cnt + 9'h001);
      end
    end

    // main source switches only on a pulse of the new source
    if (want_hs && !st_ff.main_src_status && st_ff.hs_pulse) begin
      nxt_st.main_src_status = 1'b1;
    end
    if (!want_hs && st_ff.main_src_status && st_ff.int_pulse) begin
      nxt_st.main_src_status = 1'b0;
    end

    // standby
    if (stop_req) begin
      nxt_st.stop_mode = 1'b1;
    end else if (wake_req) begin
      nxt_st.stop_mode = 1'b0;
    end
    // settle wait armed by stop; dropped once settled or back on internal
    if (stop_req) begin
      nxt_st.wake_wait = 1'b1;
    end else if (!st_ff.stop_mode && stab_done) begin
      nxt_st.wake_wait = 1'b0;
    end

    // bus: one wait cycle, read data captured during it
    nxt_st.ack = req && !st_ff.ack;
    nxt_st.rdata = 32'h0000_0000;
    case (address)
      ADR_PIN_MODE: begin
        nxt_st.rdata[BIT_EXT_CLK_SELECT] = st_ff.ext_clk_select;
        nxt_st.rdata[BIT_OSC_PIN_SELECT] = st_ff.osc_pin_select;
      end
      ADR_HS_OSC: begin
        nxt_st.rdata[BIT_HS_CLK_STOP] = st_ff.hs_clk_stop;
      end
      ADR_MAIN_MODE: begin
        nxt_st.rdata[BIT_PERIPH_SRC_SELECT] = st_ff.periph_src_select;
        nxt_st.rdata[BIT_MAIN_SRC_STATUS]   = st_ff.main_src_status;
        nxt_st.rdata[BIT_MAIN_SRC_SELECT]   = st_ff.main_src_select;
      end
      ADR_INT_OSC: begin
        nxt_st.rdata[BIT_INT_OSC_STABLE] = st_ff.int_osc_stable;
        nxt_st.rdata[BIT_INT_OSC_STOP]   = st_ff.int_osc_stop;
      end
      ADR_CPU_DIV: begin
        nxt_st.rdata[2:0] = st_ff.cpu_div;
      end
      ADR_STAB_SEL: begin
        nxt_st.rdata[2:0] = st_ff.stab_sel;
      end
      ADR_STAB_CNT: begin
        nxt_st.rdata[15:0] = st_ff.stab_cnt;
      end
      default: begin
        nxt_st.rdata = 32'h0000_0000;
      end
    endcase

    if (wr_go) begin
      case (address)
        ADR_PIN_MODE: begin
          nxt_st.ext_clk_select = writedata[BIT_EXT_CLK_SELECT];
          nxt_st.osc_pin_select = writedata[BIT_OSC_PIN_SELECT];
        end
        ADR_HS_OSC: begin
          nxt_st.hs_clk_stop = writedata[BIT_HS_CLK_STOP];
        end
        ADR_MAIN_MODE: begin
          nxt_st.main_src_select = writedata[BIT_MAIN_SRC_SELECT];
          if (!st_ff.periph_src_locked &&
              writedata[BIT_PERIPH_SRC_SELECT] != st_ff.periph_src_select) begin
            nxt_st.periph_src_select = writedata[BIT_PERIPH_SRC_SELECT];
            nxt_st.periph_src_locked = 1'b1;
          end
        end
        ADR_INT_OSC: begin
          nxt_st.int_osc_stop = writedata[BIT_INT_OSC_STOP];
        end
        ADR_CPU_DIV: begin
          // prohibited codes leave the running ratio untouched
          if (writedata[2:0] <= DIV_CODE_MAX) begin
            nxt_st.cpu_div = writedata[2:0];
          end
        end
        ADR_STAB_SEL: begin
          nxt_st.stab_sel = writedata[2:0];
        end
        default: begin
          nxt_st.stab_sel = st_ff.stab_sel;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      st_ff                 <= '0;
      st_ff.hs_clk_stop     <= RST_HS_CLK_STOP;
      st_ff.cpu_div         <= RST_CPU_DIV;
      st_ff.stab_sel        <= RST_STAB_SEL;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign readdata           = st_ff.rdata;
  assign waitrequest        = req && !st_ff.ack;
  assign xtal_amp_en        = xtal_mode && hs_run;
  assign ext_clk_in_en      = ext_mode && hs_run;
  assign port_pin_a_is_port = !xtal_mode;
  assign port_pin_b_is_port = !st_ff.osc_pin_select;
  assign stop_mode          = st_ff.stop_mode;
  // enables are whole pulses of one source, so a switch cannot cut one
  assign main_clk_en   = st_ff.main_src_status ? st_ff.hs_pulse : st_ff.int_pulse;
  assign periph_clk_en = (st_ff.periph_src_select || st_ff.main_src_status) ?
                         st_ff.hs_pulse : st_ff.int_pulse;

  assign div_if.main_en = main_clk_en;
  assign div_if.run     = !st_ff.stop_mode && stab_done;
  assign div_if.code    = st_ff.cpu_div;
  assign cpu_clk_en     = div_if.cpu_en;

  sscs_cpu_div u_div (
    .clk        (clk),
    .rst_n_sync (rst_n_sync),
    .dv         (div_if)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_int_restart;
    st_ff.int_osc_stop ##1 !st_ff.int_osc_stop;
  endsequence

  sequence s_main_write;
    write && st_ff.ack && byteenable[0] && address == ADR_MAIN_MODE;
  endsequence

  AST_XTAL_MODE: assert property (@(posedge clk) disable iff (!rst_n_sync)
    xtal_amp_en |-> st_ff.osc_pin_select && !st_ff.ext_clk_select && !port_pin_a_is_port)
    else $error("crystal amplifier on in wrong pin mode");

  AST_EXT_MODE: assert property (@(posedge clk) disable iff (!rst_n_sync)
    ext_clk_in_en |-> port_pin_a_is_port && !port_pin_b_is_port && !xtal_amp_en)
    else $error("external clock mode pin use wrong");

  AST_RESET_STATE: assert property (@(posedge clk)
    $rose(rst_n_sync) |-> port_pin_a_is_port && port_pin_b_is_port && !main_clk_en ##25 main_clk_en)
    else $error("reset state or internal start wrong");

  AST_HS_STOPPED: assert property (@(posedge clk) disable iff (!rst_n_sync)
    st_ff.hs_clk_stop |-> !xtal_amp_en && !ext_clk_in_en ##1 st_ff.stab_cnt == 16'h0000 && !st_ff.hs_pulse)
    else $error("high-speed source active while stopped");

  AST_STOP_ENTRY: assert property (@(posedge clk) disable iff (!rst_n_sync)
    stop_req |=> stop_mode && !xtal_amp_en && !ext_clk_in_en ##1 !cpu_clk_en)
    else $error("stop mode did not halt clocks");

  AST_MAIN_HS: assert property (@(posedge clk) disable iff (!rst_n_sync)
    st_ff.main_src_status |-> periph_clk_en == main_clk_en && main_clk_en == st_ff.hs_pulse)
    else $error("peripheral clock differs from high-speed main");

  AST_STATUS_SWITCH: assert property (@(posedge clk) disable iff (!rst_n_sync)
    $rose(st_ff.main_src_status) |-> $past(st_ff.hs_pulse) && $past(want_hs))
    else $error("status rose without a high-speed pulse");

  AST_PERIPH_ONCE: assert property (@(posedge clk) disable iff (!rst_n_sync)
    s_main_write and st_ff.periph_src_locked |=> $stable(st_ff.periph_src_select))
    else $error("peripheral select changed twice");

  AST_INT_RESTART: assert property (@(posedge clk) disable iff (!rst_n_sync)
    s_int_restart |-> !st_ff.int_osc_stable ##25 st_ff.int_pulse)
    else $error("internal oscillator did not restart");

  AST_INT_STABLE: assert property (@(posedge clk) disable iff (!rst_n_sync)
    $rose(st_ff.int_osc_stable) |-> $past(st_ff.int_stab_cnt) == INT_STAB_CNT_MAX)
    else $error("stable flag at wrong time");

endmodule
`default_nettype wire

// *** sscs_osc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// resonator and external clock source on the high-speed pins
// ----------------------------------------------------------------
module sscs_osc_model (
  // enables from the device
  input  wire logic xtal_amp_en,
  input  wire logic ext_clk_in_en,
  // pin levels to the device
  output logic      xtal_osc_in,
  output logic      ext_clk_pin_in
);
  // resonator swings only while the amplifier drives it
  initial begin
    xtal_osc_in = 1'b0;
    forever begin
      #20;
      xtal_osc_in = xtal_amp_en ? ~xtal_osc_in : 1'b0;
    end
  end

  // external source runs free; gating is the device's job
  initial begin
    ext_clk_pin_in = 1'b0;
    forever begin
      #15.3;
      ext_clk_pin_in = ~ext_clk_pin_in;
    end
  end
endmodule
`default_nettype wire

// *** tb_system_clock_source_select.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
  $display("wrong value t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_system_clock_source_select;
  import sscs_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk, rst_n, read, write, stop_req, wake_req, peek, peek_sel;
  logic [4:0]  address;
  logic [31:0] writedata, readdata, gap, obs;
  logic [3:0]  byteenable;
  logic        waitrequest, xtal_osc_in, ext_clk_pin_in, xtal_amp_en, ext_clk_in_en;
  logic        port_pin_a_is_port, port_pin_b_is_port, stop_mode;
  logic        main_clk_en, periph_clk_en, cpu_clk_en;
  logic [7:0]  lfsr_ff;
  logic [63:0] exp_q[$];
  logic [63:0] note;
  int          err_total, cmp_count, cyc, mc, pc;

  sscs_top DUT (.clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .xtal_osc_in(xtal_osc_in), .ext_clk_pin_in(ext_clk_pin_in),
    .xtal_amp_en(xtal_amp_en), .ext_clk_in_en(ext_clk_in_en),
    .port_pin_a_is_port(port_pin_a_is_port), .port_pin_b_is_port(port_pin_b_is_port),
    .stop_req(stop_req), .wake_req(wake_req), .stop_mode(stop_mode),
    .main_clk_en(main_clk_en), .periph_clk_en(periph_clk_en), .cpu_clk_en(cpu_clk_en));

  sscs_osc_model osc (.xtal_amp_en(xtal_amp_en), .ext_clk_in_en(ext_clk_in_en),
    .xtal_osc_in(xtal_osc_in), .ext_clk_pin_in(ext_clk_pin_in));

  assign obs = peek_sel ? gap : {27'h0, stop_mode, xtal_amp_en, ext_clk_in_en,
                                 port_pin_a_is_port, port_pin_b_is_port};

  function automatic logic [7:0] nxt_lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // ----------------------------------------------------------------
  // clock, timeout, tick spacing meter
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // main ticks low half, peripheral ticks high half, between cpu ticks
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
    if (cpu_clk_en === 1'b1) begin
      gap <= {16'(pc + (periph_clk_en === 1'b1)), 16'(mc + (main_clk_en === 1'b1))};
      mc = 0;
      pc = 0;
    end else begin
      mc = mc + (main_clk_en === 1'b1);
      pc = pc + (periph_clk_en === 1'b1);
    end
  end

  // ----------------------------------------------------------------
  // result watcher: oldest note against what appears
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if ((read === 1'b1 && waitrequest === 1'b0) || peek === 1'b1) begin
      note = exp_q.pop_front();
      if (peek === 1'b1) begin
        `CHK(obs & note[63:32], note[31:0])
      end else begin
        `CHK(readdata & note[63:32], note[31:0])
      end
    end
  end

  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
                     input logic [31:0] m, input logic [31:0] e);
    int n;
    n = 0;
    @(posedge clk);
    lfsr_ff <= nxt_lfsr(lfsr_ff);
    address <= a;
    read <= !wr;
    write <= wr;
    // upper bits carry noise: only the low byte holds fields
    writedata <= {lfsr_ff, lfsr_ff, lfsr_ff, d};
    if (!wr) exp_q.push_back({m, e});
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) err_total++;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic look(input logic sel, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    exp_q.push_back({m, e});
    peek_sel <= sel;
    peek <= 1'b1;
    @(posedge clk);
    peek <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0; read = 1'b0; write = 1'b0; address = 5'h00; writedata = 32'h0000_0000;
    byteenable = 4'hf; stop_req = 1'b0; wake_req = 1'b0; peek = 1'b0; peek_sel = 1'b0;
    lfsr_ff = 8'h5c; err_total = 0; cmp_count = 0; cyc = 0; mc = 0; gap = 32'h0000_0000; pc = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    idle(3);
    look(1'b0, 32'h0000_001f, 32'h0000_0003);
    bus(1'b0, ADR_PIN_MODE, 8'h00, 32'h0000_00c0, 32'h0000_0000);
    bus(1'b0, ADR_HS_OSC, 8'h00, 32'h0000_0080, 32'h0000_0080);
    bus(1'b0, ADR_MAIN_MODE, 8'h00, 32'h0000_0007, 32'h0000_0000);
    bus(1'b0, ADR_CPU_DIV, 8'h00, 32'h0000_0007, 32'h0000_0001);
    bus(1'b0, ADR_STAB_SEL, 8'h00, 32'h0000_0007, 32'h0000_0007);
    bus(1'b0, 5'h1c, 8'h00, 32'hffff_ffff, 32'h0000_0000);
    idle(300);
    bus(1'b0, ADR_INT_OSC, 8'h00, 32'h0000_0081, 32'h0000_0080);
    look(1'b1, 32'hffff_ffff, 32'h0002_0002);
    // crystal mode, then start the amplifier
    bus(1'b1, ADR_PIN_MODE, 8'h40, 32'h0, 32'h0);
    look(1'b0, 32'h0000_001f, 32'h0000_0000);
    bus(1'b1, ADR_HS_OSC, 8'h00, 32'h0, 32'h0);
    look(1'b0, 32'h0000_001f, 32'h0000_0008);
    idle(300); // settling wait before switching over
    bus(1'b1, ADR_MAIN_MODE, 8'h05, 32'h0, 32'h0);
    idle(100);
    bus(1'b0, ADR_MAIN_MODE, 8'h00, 32'h0000_0007, 32'h0000_0007);
    bus(1'b1, ADR_MAIN_MODE, 8'h01, 32'h0, 32'h0);
    bus(1'b0, ADR_MAIN_MODE, 8'h00, 32'h0000_0007, 32'h0000_0007);
    for (int k = 0; k <= 4; k++) begin
      bus(1'b1, ADR_CPU_DIV, k[7:0], 32'h0, 32'h0);
      idle(600);
      look(1'b1, 32'hffff_ffff, 32'h0001_0001 << k);
      bus(1'b0, ADR_CPU_DIV, 8'h00, 32'h0000_0007, k);
    end
    bus(1'b1, ADR_CPU_DIV, 8'h05, 32'h0, 32'h0);
    bus(1'b0, ADR_CPU_DIV, 8'h00, 32'h0000_0007, 32'h0000_0004);
    bus(1'b1, 5'h1c, lfsr_ff, 32'h0, 32'h0);
    bus(1'b0, 5'h1c, 8'h00, 32'hffff_ffff, 32'h0000_0000);
    // main back to internal, periph left on high-speed, before halting the high-speed clock
    bus(1'b1, ADR_MAIN_MODE, 8'h04, 32'h0, 32'h0);
    idle(100);
    bus(1'b0, ADR_MAIN_MODE, 8'h00, 32'h0000_0007, 32'h0000_0004);
    bus(1'b1, ADR_HS_OSC, 8'h80, 32'h0, 32'h0);
    look(1'b0, 32'h0000_001f, 32'h0000_0000);
    // external clock input mode
    bus(1'b1, ADR_PIN_MODE, 8'hc0, 32'h0, 32'h0);
    look(1'b0, 32'h0000_001f, 32'h0000_0002);
    bus(1'b1, ADR_HS_OSC, 8'h00, 32'h0, 32'h0);
    look(1'b0, 32'h0000_001f, 32'h0000_0006);
    bus(1'b1, ADR_STAB_SEL, 8'h03, 32'h0, 32'h0);
    bus(1'b0, ADR_STAB_SEL, 8'h00, 32'h0000_0007, 32'h0000_0003);
    @(posedge clk);
    stop_req <= 1'b1;
    @(posedge clk);
    stop_req <= 1'b0;
    idle(2);
    look(1'b0, 32'h0000_001f, 32'h0000_0012);
    @(posedge clk);
    wake_req <= 1'b1;
    @(posedge clk);
    wake_req <= 1'b0;
    idle(50);
    look(1'b0, 32'h0000_0010, 32'h0000_0000);
    // internal oscillator stop and restart
    bus(1'b1, ADR_INT_OSC, 8'h01, 32'h0, 32'h0);
    idle(10);
    bus(1'b1, ADR_INT_OSC, 8'h00, 32'h0, 32'h0);
    idle(300);
    bus(1'b0, ADR_INT_OSC, 8'h00, 32'h0000_0081, 32'h0000_0080);
    idle(2);
    stop_test();
  end
endmodule
`default_nettype wire
